// ===== rtl/eoc_output_ctrl.v
// Purpose: mode, serial command and output control of the engine output driver
// Assumes: all pins asynchronous to i_clk; sclk far slower than i_clk
// Notes: sleep, battery loss and the reset command return all settings to reset values
`timescale 1ns/1ps
`include "eoc_regs.vh"

module eoc_output_ctrl #(
  parameter FILT_STEP_CYC = `EOC_FILT_STEP_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_enable,
  input wire i_battery_supply,
  input wire i_fallback,
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_si,
  output reg o_so,
  output wire o_so_oe,
  input wire [5:0] i_pwm,
  input wire [3:0] i_direct_switch_inputs,
  input wire [5:0] i_drain_sense_input,
  input wire [7:0] i_low_side_fault,
  input wire [1:0] i_regulator_fault,
  output reg [5:0] o_gate_drive_output,
  output reg [7:0] o_low_side_outputs,
  output reg o_current_regulator_one,
  output reg o_current_regulator_two,
  output reg [2:0] o_resistance_feedback_output,
  output reg [3:0] o_drain_threshold,
  output wire o_sleep
);
  wire [31:0] sync_q;
  wire cs_s;
  wire sclk_s;
  wire si_s;
  wire en_s;
  wire batt_s;
  wire fb_s;
  wire [5:0] pwm_s;
  wire [3:0] dir_s;
  wire [5:0] drain_s;
  wire [7:0] lsw_flt_s;
  wire [1:0] creg_flt_s;

  eoc_sync #(.WIDTH(32)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({~i_cs_n, i_sclk, i_si, i_enable, i_battery_supply, i_fallback, i_pwm,
          i_direct_switch_inputs, i_drain_sense_input, i_low_side_fault, i_regulator_fault}),
    .o_q(sync_q)
  );

  // select travels inverted so the cleared synchroniser reads as deselected
  assign cs_s = ~sync_q[31];
  assign sclk_s = sync_q[30];
  assign si_s = sync_q[29];
  assign en_s = sync_q[28];
  assign batt_s = sync_q[27];
  assign fb_s = sync_q[26];
  assign pwm_s = sync_q[25:20];
  assign dir_s = sync_q[19:16];
  assign drain_s = sync_q[15:10];
  assign lsw_flt_s = sync_q[9:2];
  assign creg_flt_s = sync_q[1:0];

  // edge history of the serial pins
  reg cs_d;
  reg sclk_d;
  always @(posedge i_clk) begin
    if (i_rst) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_s;
      sclk_d <= sclk_s;
    end
  end
  wire cs_fall = cs_d & ~cs_s;
  wire cs_rise = ~cs_d & cs_s;
  wire sclk_rise = ~cs_s & ~sclk_d & sclk_s;
  wire sclk_fall = ~cs_s & sclk_d & ~sclk_s;

  // mode
  assign o_sleep = ~en_s;
  wire fallback = fb_s;
  reg reset_cmd;
  wire logic_rst = i_rst | ~en_s | ~batt_s | reset_cmd;

  // settings
  reg [5:0] gate_on;
  reg and_mode;
  reg [7:0] lsw_on;
  reg lsw_dir;
  reg lsw_pair;
  reg [5:0] gen_en;
  reg [23:0] duty;
  reg [3:0] freq;
  reg [3:0] filt;
  reg [2:0] fdbk_ch;
  reg [1:0] creg_on;

  // serial chain: one register shifts status out and command in
  reg [15:0] chain;
  reg [7:0] pulses;
  reg [5:0] gd_flt;
  reg [7:0] lsw_flt;
  reg [1:0] creg_flt;
  wire [15:0] status = {creg_flt, lsw_flt, gd_flt};
  wire frame_ok = (pulses >= `EOC_MIN_PULSES) && (pulses[2:0] == 3'h0);
  wire apply = cs_rise & frame_ok;
  wire [3:0] op = chain[`EOC_OP_HI:`EOC_OP_LO];

  assign o_so_oe = ~cs_s;

  always @(posedge i_clk) begin
    if (logic_rst) begin
      chain <= 16'h0000;
      pulses <= 8'h00;
      o_so <= 1'b0;
    end else if (cs_fall) begin
      chain <= status;
      pulses <= 8'h00;
      o_so <= status[15];
    end else begin
      if (sclk_rise) begin
        chain <= {chain[14:0], si_s};
        if (pulses != 8'hff) begin
          pulses <= pulses + 8'h01;
        end
      end
      if (sclk_fall) begin
        o_so <= chain[15];
      end
    end
  end

  // command register writes
  always @(posedge i_clk) begin
    if (logic_rst) begin
      gate_on <= `EOC_RST_GATE_ON;
      and_mode <= `EOC_RST_AND_MODE;
      lsw_on <= `EOC_RST_LSW_ON;
      lsw_dir <= `EOC_RST_LSW_DIR;
      lsw_pair <= `EOC_RST_LSW_PAIR;
      gen_en <= 6'h00;
      duty <= 24'h000000;
      freq <= 4'h0;
      filt <= `EOC_RST_FILT;
      o_drain_threshold <= `EOC_RST_THRESH;
      fdbk_ch <= `EOC_RST_FDBK;
      creg_on <= `EOC_RST_CREG;
      reset_cmd <= 1'b0;
    end else if (apply) begin
      case (op)
        `EOC_OP_GATE: begin
          gate_on <= chain[5:0];
          and_mode <= chain[`EOC_GATE_AND_BIT];
        end
        `EOC_OP_LSW: begin
          lsw_on <= chain[7:0];
          lsw_dir <= chain[`EOC_LSW_DIR_BIT];
          lsw_pair <= chain[`EOC_LSW_PAIR_BIT];
        end
        `EOC_OP_PWM: begin
          if (chain[2:0] < 3'h6) begin
            gen_en[chain[2:0]] <= chain[`EOC_PWM_EN_BIT];
            duty[chain[2:0]*4 +: 4] <= chain[7:4];
          end
          freq <= chain[11:8];
        end
        `EOC_OP_DRAIN: begin
          filt <= chain[3:0];
          o_drain_threshold <= chain[7:4];
        end
        `EOC_OP_FDBK: begin
          fdbk_ch <= chain[2:0];
        end
        `EOC_OP_CREG: begin
          creg_on <= chain[1:0];
        end
        `EOC_OP_RESET: begin
          reset_cmd <= 1'b1;
        end
        default: begin
          reset_cmd <= 1'b0;
        end
      endcase
    end
  end

  // pwm generator: shared prescaler and 4-bit phase
  reg [3:0] presc;
  reg [3:0] phase;
  always @(posedge i_clk) begin
    if (logic_rst) begin
      presc <= 4'h0;
      phase <= 4'h0;
    end else if (presc >= freq) begin
      presc <= 4'h0;
      phase <= phase + 4'h1;
    end else begin
      presc <= presc + 4'h1;
    end
  end

  // per gate channel: drive and drain filter
  wire [5:0] gd_short;
  wire [5:0] gd_open;
  wire [5:0] gd_drive;
  wire [19:0] filt_limit = (({16'h0000, filt} + 20'h00001) * FILT_STEP_CYC[19:0]);
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_gate
      wire gen_out = (phase < duty[g*4 +: 4]);
      wire src = gen_en[g] ? gen_out : gate_on[g];
      wire mix = and_mode ? (pwm_s[g] & src) : (pwm_s[g] | src);
      wire drive = fallback ? pwm_s[g] : mix;
      reg [19:0] fcnt;
      reg fstate;
      // short when on with high drain, open when off with low drain
      wire cond = (drive & drain_s[g]) | (~drive & ~drain_s[g]);
      assign gd_drive[g] = drive;
      always @(posedge i_clk) begin
        if (logic_rst) begin
          fcnt <= 20'h00000;
          fstate <= 1'b0;
        end else begin
          fstate <= drive;
          if (~cond || (fstate != drive)) begin
            fcnt <= 20'h00000;
          end else if (fcnt < filt_limit) begin
            fcnt <= fcnt + 20'h00001;
          end
        end
      end
      assign gd_short[g] = fstate & (fcnt >= filt_limit);
      assign gd_open[g] = ~fstate & (fcnt >= filt_limit);
    end
  endgenerate

  // sticky faults, set wins over the clear at status load; kept in fallback
  always @(posedge i_clk) begin
    if (logic_rst) begin
      gd_flt <= 6'h00;
      lsw_flt <= 8'h00;
      creg_flt <= 2'h0;
    end else begin
      gd_flt <= (cs_fall ? 6'h00 : gd_flt) | gd_short | gd_open;
      lsw_flt <= (cs_fall ? 8'h00 : lsw_flt) | lsw_flt_s;
      creg_flt <= (cs_fall ? 2'h0 : creg_flt) | creg_flt_s;
    end
  end

  // low-side outputs
  reg [7:0] next_lsw;
  integer k;
  always @* begin
    next_lsw = lsw_on;
    for (k = 0; k < 4; k = k + 1) begin
      if (lsw_dir) begin
        next_lsw[2*k] = lsw_on[2*k] | dir_s[k];
        if (lsw_pair) begin
          next_lsw[2*k+1] = lsw_on[2*k+1] | dir_s[k];
        end
      end
    end
    if (fallback) begin
      next_lsw = 8'h00;
    end
  end

  always @(posedge i_clk) begin
    if (logic_rst) begin
      o_gate_drive_output <= 6'h00;
      o_low_side_outputs <= 8'h00;
      o_current_regulator_one <= 1'b0;
      o_current_regulator_two <= 1'b0;
      o_resistance_feedback_output <= 3'h0;
    end else begin
      o_gate_drive_output <= gd_drive & {6{en_s}};
      o_low_side_outputs <= next_lsw;
      o_current_regulator_one <= creg_on[0] & ~fallback;
      o_current_regulator_two <= creg_on[1] & ~fallback;
      o_resistance_feedback_output <= fdbk_ch;
    end
  end
endmodule // eoc_output_ctrl

// ===== include/eoc_regs.vh
// Purpose: constants of the engine output control block
// Assumes: 16-bit command words, opcode in the top nibble
// Notes: field positions are bit indices inside the received command word
`ifndef EOC_REGS_VH
`define EOC_REGS_VH

`define EOC_WORD_BITS 16
`define EOC_MIN_PULSES 8'h10
`define EOC_OP_HI 15
`define EOC_OP_LO 12
// opcodes
`define EOC_OP_GATE 4'h1
`define EOC_OP_LSW 4'h2
`define EOC_OP_PWM 4'h3
`define EOC_OP_DRAIN 4'h4
`define EOC_OP_FDBK 4'h5
`define EOC_OP_CREG 4'h6
`define EOC_OP_RESET 4'h7
// gate word: [5:0] spi on bits, [6] and-mode, [11:7] unused
`define EOC_GATE_AND_BIT 6
// low-side word: [7:0] on bits, [8] direct inputs enabled, [9] pair mode
`define EOC_LSW_DIR_BIT 8
`define EOC_LSW_PAIR_BIT 9
// pwm word: [2:0] channel, [3] generator enable, [7:4] duty, [11:8] frequency code
`define EOC_PWM_EN_BIT 3
// drain word: [3:0] filter code, [7:4] threshold code
// feedback word: [2:0] channel; regulator word: [1:0] on bits
// reset values
`define EOC_RST_GATE_ON 6'h00
`define EOC_RST_AND_MODE 1'h0
`define EOC_RST_LSW_ON 8'h00
`define EOC_RST_LSW_DIR 1'h1
`define EOC_RST_LSW_PAIR 1'h0
`define EOC_RST_FILT 4'h0
`define EOC_RST_THRESH 4'h0
`define EOC_RST_FDBK 3'h0
`define EOC_RST_CREG 2'h0
// drain filter step: filter time is (code + 1) steps
`define EOC_FILT_STEP_US 30
`define EOC_CLK_MHZ 100
`define EOC_FILT_STEP_CYC (`EOC_FILT_STEP_US * `EOC_CLK_MHZ)

`endif

// ===== rtl/eoc_sync.v
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: bits are independent levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module eoc_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_d,
  output reg [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] stage1;

  always @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= {WIDTH{1'b0}};
      o_q <= {WIDTH{1'b0}};
    end else begin
      stage1 <= i_d;
      o_q <= stage1;
    end
  end
endmodule // eoc_sync

// ===== test/eoc_checker.sv
// Purpose: port checker of the output control block
// Assumes: synchronised pins lag about three cycles
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module eoc_checker (
  input wire i_clk,
  input wire i_rst,
  input wire i_enable,
  input wire i_fallback,
  input wire i_cs_n,
  input wire [5:0] i_pwm,
  input wire [3:0] i_direct_switch_inputs,
  input wire o_so_oe,
  input wire [5:0] o_gate_drive_output,
  input wire [7:0] o_low_side_outputs,
  input wire o_current_regulator_one,
  input wire o_current_regulator_two,
  input wire o_sleep
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  so_off_a: assert property ($rose(i_cs_n) |-> ##[1:3] !o_so_oe) else $error("so still driven");
  so_on_a: assert property ($fell(i_cs_n) |-> ##[1:3] o_so_oe) else $error("so not driven");
  sleep_flag_a: assert property (!i_enable [*4] |-> o_sleep) else $error("no sleep");
  awake_flag_a: assert property (i_enable [*4] |-> !o_sleep) else $error("stuck asleep");
  sleep_quiet_a:
    assert property (o_sleep [*3] |-> o_gate_drive_output == 6'h00 && o_low_side_outputs == 8'h00)
    else $error("outputs on in sleep");
  fb_quiet_a:
    assert property (i_fallback [*5] |-> o_low_side_outputs == 8'h00 && !o_current_regulator_one
      && !o_current_regulator_two) else $error("outputs on in fallback");
  fb_follow_a:
    assert property ((i_fallback && i_enable && $stable(i_pwm)) [*6] |-> o_gate_drive_output == i_pwm)
    else $error("gate not following pin");
  direct_pin_a:
    assert property ((!i_fallback && i_enable && $stable(i_direct_switch_inputs)) [*6] |->
      (o_low_side_outputs | ~{1'b0, i_direct_switch_inputs[3], 1'b0, i_direct_switch_inputs[2], 1'b0,
      i_direct_switch_inputs[1], 1'b0, i_direct_switch_inputs[0]}) == 8'hff) else $error("direct pin ignored");
endmodule // eoc_checker

bind eoc_output_ctrl eoc_checker eoc_checker_i (.i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable),
  .i_fallback(i_fallback), .i_cs_n(i_cs_n), .i_pwm(i_pwm), .i_direct_switch_inputs(i_direct_switch_inputs),
  .o_so_oe(o_so_oe), .o_gate_drive_output(o_gate_drive_output), .o_low_side_outputs(o_low_side_outputs),
  .o_current_regulator_one(o_current_regulator_one), .o_current_regulator_two(o_current_regulator_two),
  .o_sleep(o_sleep));

// ===== test/eoc_host_model.sv
// Purpose: host side model driving the serial pins
// Assumes: i_clk is the bench clock
// Notes: sclk half period is 8 cycles and stays low between frames
`timescale 1ns/1ps
module eoc_host_model (
  input wire i_clk,
  input wire i_so,
  output reg o_cs_n,
  output reg o_sclk,
  output reg o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  task automatic xfer(input logic [31:0] wd, input int n, output logic [31:0] rd);
    rd = 32'h0;
    o_cs_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    for (int k = n - 1; k >= 0; k--) begin
      o_si <= wd[k];
      repeat (8) @(posedge i_clk);
      rd = {rd[30:0], i_so};
      o_sclk <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    repeat (8) @(posedge i_clk);
  endtask
endmodule // eoc_host_model

// ===== test/test_eoc_output_ctrl.sv
// Purpose: self-checking bench of the output control block
// Assumes: drain sense held high so idle gates raise no faults
// Notes: filter step shortened to 10 cycles
`timescale 1ns/1ps
module test_eoc_output_ctrl;
  logic i_clk = 0, i_rst = 1, i_enable = 1, i_battery_supply = 1, i_fallback = 0;
  logic [5:0] i_pwm = 6'h00, i_drain_sense_input = 6'h3f;
  logic [3:0] i_direct_switch_inputs = 4'h0;
  logic [7:0] i_low_side_fault = 8'h00;
  logic [1:0] i_regulator_fault = 2'h0;
  wire i_cs_n, i_sclk, i_si, o_so, o_so_oe, o_current_regulator_one, o_current_regulator_two, o_sleep;
  wire [5:0] o_gate_drive_output;
  wire [7:0] o_low_side_outputs;
  wire [2:0] o_resistance_feedback_output;
  wire [3:0] o_drain_threshold;
  logic [31:0] r;
  int bad_count = 0, checks_done = 0;
  always #5 i_clk = ~i_clk;
  eoc_output_ctrl #(.FILT_STEP_CYC(10)) eoc_output_ctrl_i (.i_clk, .i_rst, .i_enable, .i_battery_supply,
    .i_fallback, .i_cs_n, .i_sclk, .i_si, .o_so, .o_so_oe, .i_pwm, .i_direct_switch_inputs,
    .i_drain_sense_input, .i_low_side_fault, .i_regulator_fault, .o_gate_drive_output, .o_low_side_outputs,
    .o_current_regulator_one, .o_current_regulator_two, .o_resistance_feedback_output, .o_drain_threshold,
    .o_sleep);
  // a released serial output shows the inverse of its last level to the host
  eoc_host_model eoc_host_model_i (.i_clk, .i_so(o_so_oe ? o_so : ~o_so), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
    .o_si(i_si));
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic send(input logic [31:0] wd, input int n = 16);
    eoc_host_model_i.xfer(wd, n, r);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    conclude;
  end
  initial begin
    w(6);
    chk("oe reset", o_so_oe, 1'b0);
    i_rst <= 1'b0;
    w(6);
    i_direct_switch_inputs <= 4'h5;
    w(6);
    chk("direct", o_low_side_outputs, 8'h11);
    send(32'h2300);
    chk("pair", o_low_side_outputs, 8'h33);
    i_direct_switch_inputs <= 4'h0;
    i_low_side_fault <= 8'h01;
    i_regulator_fault <= 2'h2;
    w(4);
    i_low_side_fault <= 8'h00;
    i_regulator_fault <= 2'h0;
    w(4);
    send(32'h0);
    chk("status", r[15:0], 16'h8040);
    send(32'h0);
    chk("status idle", r[15:0], 16'h0000);
    $display("test pins and status done");
    send(32'ha55003, 24);
    chk("echo", r[7:0], 8'ha5);
    chk("fdbk", o_resistance_feedback_output, 3'h3);
    for (int n = 15; n <= 17; n += 2) begin
      send(32'h5005, n);
      chk("odd frame", o_resistance_feedback_output, 3'h3);
    end
    send(32'h4050);
    chk("thresh", o_drain_threshold, 4'h5);
    i_pwm <= 6'h02;
    send(32'h1005);
    chk("or mode", o_gate_drive_output, 6'h07);
    send(32'h1045);
    chk("and mode", o_gate_drive_output, 6'h00);
    i_pwm <= 6'h05;
    w(6);
    chk("and pin", o_gate_drive_output, 6'h05);
    send(32'h3008);
    chk("gate fault", r[15:0], 16'h0007);
    chk("gen duty", o_gate_drive_output, 6'h04);
    $display("test frames and gates done");
    send(32'h21f0);
    send(32'h6003);
    chk("lsw", {o_current_regulator_one, o_current_regulator_two, o_low_side_outputs}, 10'h3f0);
    i_fallback <= 1'b1;
    i_pwm <= 6'h2a;
    w(8);
    chk("fb", {o_current_regulator_one, o_current_regulator_two, o_low_side_outputs}, 10'h000);
    chk("fb gate", o_gate_drive_output, 6'h2a);
    i_fallback <= 1'b0;
    w(8);
    chk("resume", {o_current_regulator_one, o_current_regulator_two, o_low_side_outputs}, 10'h3f0);
    chk("resume gate", o_gate_drive_output, 6'h00);
    $display("test fallback done");
    i_enable <= 1'b0;
    w(6);
    chk("sleep", {o_sleep, o_low_side_outputs}, 9'h100);
    i_enable <= 1'b1;
    w(6);
    chk("wake", {o_sleep, o_drain_threshold, o_resistance_feedback_output}, 8'h00);
    send(32'h5006);
    chk("fdbk", o_resistance_feedback_output, 3'h6);
    i_battery_supply <= 1'b0;
    w(6);
    i_battery_supply <= 1'b1;
    w(6);
    chk("battery", o_resistance_feedback_output, 3'h0);
    send(32'h5006);
    send(32'h7000);
    chk("reset cmd", o_resistance_feedback_output, 3'h0);
    $display("test sleep and supply done");
    conclude;
  end
endmodule // test_eoc_output_ctrl
